// ==== design/mmsd_pkg.sv ====
`default_nettype none
package mmsd_pkg;
	// ==========================================
	// data space
	localparam logic [7:0]  DATA_UPPER_BASE = 8'h80;
	localparam logic [7:0]  BANK_REGION_END = 8'h1f;
	localparam logic [7:0]  BIT_REGION_BASE = 8'h20;
	localparam logic [7:0]  BIT_REGION_END  = 8'h2f;
	localparam int          BANK_BYTES      = 8;
	localparam int          BANK_SHIFT      = 3;
	// ==========================================
	// extra data ram and flash
	localparam int          EXTRA_RAM_BYTES = 1024;
	localparam logic [15:0] EXTRA_RAM_LAST  = 16'h03ff;
	localparam int          SECTOR_BYTES    = 512;
	localparam int          SECTOR_SHIFT    = 9;
	localparam logic [15:0] FACT_BASE       = 16'h1e00;
	localparam logic [15:0] FACT_LAST       = 16'h1fff;
	localparam logic [15:0] USER_SEC_BASE   = 16'h2000;
	localparam logic [15:0] USER_SEC_LAST   = 16'h207f;
	localparam logic [15:0] USER_SEC_INDEX  = 16'h0010;

	// ==========================================
	// target encoding, one-hot except none, which is all zero
	typedef enum logic [3:0] {
		MMSD_TGT_NONE    = 4'h0,
		MMSD_TGT_LOW     = 4'h1,
		MMSD_TGT_UPPER   = 4'h2,
		MMSD_TGT_SPECIAL = 4'h4,
		MMSD_TGT_EXTRA   = 4'h8
	} mmsd_target_t;

	typedef enum logic [1:0] {
		MMSD_DIRECT   = 2'h0,
		MMSD_INDIRECT = 2'h1,
		MMSD_REGREF   = 2'h2,
		MMSD_EXTDATA  = 2'h3
	} mmsd_mode_t;

	typedef struct packed {
		logic         valid;
		mmsd_mode_t   mode;
		logic [15:0]  addr;
		logic [1:0]   bank;
	} mmsd_data_req_t;

	typedef struct packed {
		logic         valid;
		mmsd_target_t target;
		logic [9:0]   index;
		logic         bit_region;
		logic         bank_region;
	} mmsd_data_rsp_t;

	typedef struct packed {
		logic         valid;
		logic         user;
		logic         factory;
		logic         extra_sector;
		logic         invalid;
		logic [4:0]   sector;
	} mmsd_code_rsp_t;
endpackage
`default_nettype wire

// ==== design/mmsd_decoder.sv ====
// How it works
// - indirect access at or above 0x80 goes to upper internal ram
// - direct access at or above 0x80 goes to special function register space
// - lower 128 bytes decode the same for direct and indirect modes
// - lowest 32 bytes form four register banks; references resolve into chosen bank
// - 16 bytes after banks are flagged byte and bit addressable
// - build option adds 1024-byte extra data ram in external data space
// - flash is handled in 512-byte sectors; sector number reported per access
// - flash 0x1e00 to 0x1fff is factory reserved, not user space
// - extra user sector of 128 bytes decoded at 0x2000 to 0x207f
`timescale 1ns/1ps
`default_nettype none
module mmsd_decoder #(
	parameter bit HAS_EXTRA_RAM = 1'b1
) (
	input  wire logic                    i_sys_clk,
	input  wire logic                    i_rst,
	input  wire mmsd_pkg::mmsd_data_req_t i_data_req,
	input  wire logic                    i_code_valid,
	input  wire logic [15:0]             i_code_addr,
	output var  mmsd_pkg::mmsd_data_rsp_t o_data_rsp,
	output var  mmsd_pkg::mmsd_code_rsp_t o_code_rsp
);
	// ==========================================
	// data space decode
	mmsd_pkg::mmsd_data_rsp_t nxt_data_rsp;
	mmsd_pkg::mmsd_data_rsp_t data_rsp_ff;
	logic [7:0]               reg_addr;

	always_comb begin
		reg_addr = {3'h0, i_data_req.bank, i_data_req.addr[2:0]};
		nxt_data_rsp = '0;
		nxt_data_rsp.valid = i_data_req.valid;
		case (i_data_req.mode)
			mmsd_pkg::MMSD_REGREF: begin
				nxt_data_rsp.target = mmsd_pkg::MMSD_TGT_LOW;
				nxt_data_rsp.index = {2'h0, reg_addr};
			end
			mmsd_pkg::MMSD_EXTDATA: begin
				if (HAS_EXTRA_RAM && i_data_req.addr <= mmsd_pkg::EXTRA_RAM_LAST) begin
					nxt_data_rsp.target = mmsd_pkg::MMSD_TGT_EXTRA;
					nxt_data_rsp.index = i_data_req.addr[9:0];
				end else begin
					nxt_data_rsp.target = mmsd_pkg::MMSD_TGT_NONE;
				end
			end
			default: begin
				nxt_data_rsp.index = {2'h0, i_data_req.addr[7:0]};
				if (i_data_req.addr[7:0] < mmsd_pkg::DATA_UPPER_BASE) begin
					nxt_data_rsp.target = mmsd_pkg::MMSD_TGT_LOW;
				end else if (i_data_req.mode == mmsd_pkg::MMSD_INDIRECT) begin
					nxt_data_rsp.target = mmsd_pkg::MMSD_TGT_UPPER;
				end else begin
					nxt_data_rsp.target = mmsd_pkg::MMSD_TGT_SPECIAL;
				end
			end
		endcase
		if (nxt_data_rsp.target == mmsd_pkg::MMSD_TGT_LOW) begin
			nxt_data_rsp.bank_region = nxt_data_rsp.index[7:0] <= mmsd_pkg::BANK_REGION_END;
			nxt_data_rsp.bit_region = nxt_data_rsp.index[7:0] >= mmsd_pkg::BIT_REGION_BASE
				&& nxt_data_rsp.index[7:0] <= mmsd_pkg::BIT_REGION_END;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			data_rsp_ff <= '0;
		end else begin
			data_rsp_ff <= nxt_data_rsp;
		end
	end
	assign o_data_rsp = data_rsp_ff;

	// ==========================================
	// program flash decode
	mmsd_pkg::mmsd_code_rsp_t nxt_code_rsp;
	mmsd_pkg::mmsd_code_rsp_t code_rsp_ff;

	always_comb begin
		nxt_code_rsp = '0;
		nxt_code_rsp.valid = i_code_valid;
		nxt_code_rsp.sector = 5'(i_code_addr >> mmsd_pkg::SECTOR_SHIFT);
		if (i_code_addr >= mmsd_pkg::FACT_BASE && i_code_addr <= mmsd_pkg::FACT_LAST) begin
			nxt_code_rsp.factory = 1'b1;
		end else if (i_code_addr < mmsd_pkg::FACT_BASE) begin
			nxt_code_rsp.user = 1'b1;
		end else if (i_code_addr <= mmsd_pkg::USER_SEC_LAST) begin
			nxt_code_rsp.extra_sector = 1'b1;
			nxt_code_rsp.sector = mmsd_pkg::USER_SEC_INDEX[4:0];
		end else begin
			nxt_code_rsp.invalid = 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			code_rsp_ff <= '0;
		end else begin
			code_rsp_ff <= nxt_code_rsp;
		end
	end
	assign o_code_rsp = code_rsp_ff;

	// ==========================================
	// checks: data space
	chk_indirect_upper: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_data_req.valid && i_data_req.mode == mmsd_pkg::MMSD_INDIRECT && i_data_req.addr[7]
		|=> o_data_rsp.target == mmsd_pkg::MMSD_TGT_UPPER)
		else $error("indirect upper access not routed to upper ram");

	chk_upper_index: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_data_req.valid && i_data_req.mode == mmsd_pkg::MMSD_INDIRECT && i_data_req.addr[7]
		|=> o_data_rsp.index == {2'h0, $past(i_data_req.addr[7:0])})
		else $error("upper ram index differs from address");

	chk_direct_special: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_data_req.valid && i_data_req.mode == mmsd_pkg::MMSD_DIRECT && i_data_req.addr[7]
		|=> o_data_rsp.target == mmsd_pkg::MMSD_TGT_SPECIAL)
		else $error("direct upper access not routed to special register space");

	chk_special_index: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_data_req.valid && i_data_req.mode == mmsd_pkg::MMSD_DIRECT && i_data_req.addr[7]
		|=> o_data_rsp.index == {2'h0, $past(i_data_req.addr[7:0])})
		else $error("special register index differs from address");

	chk_lower_same: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_data_req.valid && !i_data_req.mode[1] && !i_data_req.addr[7]
		|=> o_data_rsp.target == mmsd_pkg::MMSD_TGT_LOW
			&& o_data_rsp.index[7:0] == $past(i_data_req.addr[7:0]))
		else $error("lower ram decode differs by mode");

	chk_bank_offset: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_data_req.valid && i_data_req.mode == mmsd_pkg::MMSD_REGREF
		|=> o_data_rsp.bank_region
			&& o_data_rsp.index == 10'(($past(i_data_req.bank) * 8) + $past(i_data_req.addr[2:0])))
		else $error("register reference resolved to wrong bank");

	chk_regref_low: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_data_req.valid && i_data_req.mode == mmsd_pkg::MMSD_REGREF
		|=> o_data_rsp.target == mmsd_pkg::MMSD_TGT_LOW)
		else $error("register reference left lower ram");

	chk_bank_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_data_req.valid && !i_data_req.mode[1] && i_data_req.addr[7:5] == 3'h0
		|=> o_data_rsp.bank_region)
		else $error("register bank byte not flagged");

	chk_bank_bound: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_data_rsp.bank_region |-> o_data_rsp.target == mmsd_pkg::MMSD_TGT_LOW
			&& o_data_rsp.index[9:5] == 5'h00)
		else $error("bank flag outside the register banks");

	chk_bank_sel: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_data_req.valid && i_data_req.mode == mmsd_pkg::MMSD_REGREF
		|=> o_data_rsp.index[4:3] == $past(i_data_req.bank))
		else $error("bank select not applied");

	chk_bit_region: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_data_rsp.bit_region |-> o_data_rsp.index[7:4] == 4'h2)
		else $error("bit region flag outside its bytes");

	chk_bit_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_data_req.valid && !i_data_req.mode[1] && i_data_req.addr[7:4] == 4'h2
		|=> o_data_rsp.bit_region)
		else $error("bit addressable byte not flagged");

	chk_extra_range: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_data_rsp.target == mmsd_pkg::MMSD_TGT_EXTRA |-> HAS_EXTRA_RAM
			&& $past(i_data_req.addr) < 16'h0400)
		else $error("extra data ram selected out of range");

	chk_extra_hit: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_data_req.valid && i_data_req.mode == mmsd_pkg::MMSD_EXTDATA
			&& i_data_req.addr <= 16'h03ff
		|=> o_data_rsp.target == (HAS_EXTRA_RAM ? mmsd_pkg::MMSD_TGT_EXTRA
			: mmsd_pkg::MMSD_TGT_NONE))
		else $error("extra data ram access misrouted");

	chk_extra_miss: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_data_req.valid && i_data_req.mode == mmsd_pkg::MMSD_EXTDATA
			&& i_data_req.addr > 16'h03ff
		|=> o_data_rsp.target == mmsd_pkg::MMSD_TGT_NONE)
		else $error("access beyond extra data ram accepted");

	// ==========================================
	// checks: program flash
	chk_factory_range: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_code_valid && i_code_addr[15:9] == 7'h0f |=> o_code_rsp.factory && !o_code_rsp.user)
		else $error("factory range not reserved");

	chk_user_range: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_code_valid && i_code_addr < 16'h1e00
		|=> o_code_rsp.user && !o_code_rsp.factory && !o_code_rsp.extra_sector)
		else $error("user flash decoded as reserved");

	chk_sector_num: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_code_valid && i_code_addr < 16'h1e00 |=> o_code_rsp.sector == $past(i_code_addr[13:9]))
		else $error("wrong flash sector number");

	chk_sector_fixed: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_code_rsp.factory |-> o_code_rsp.sector == 5'h0f)
		else $error("factory range reported in wrong sector");

	chk_extra_sector: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_code_valid && i_code_addr[15:7] == 9'h040 |=> o_code_rsp.extra_sector)
		else $error("extra user sector not decoded");

	chk_extra_number: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_code_rsp.extra_sector |-> o_code_rsp.sector == 5'h10)
		else $error("extra sector reported with wrong number");

	chk_past_extra: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_code_valid && i_code_addr > 16'h207f
		|=> o_code_rsp.invalid && !o_code_rsp.extra_sector && !o_code_rsp.user)
		else $error("address past extra sector accepted");

	chk_code_onehot: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_code_rsp.valid |-> $onehot({o_code_rsp.user, o_code_rsp.factory,
			o_code_rsp.extra_sector, o_code_rsp.invalid}))
		else $error("flash address in more than one range");

	// ==========================================
	// coverage
	cov_upper: cover property (@(posedge i_sys_clk) o_data_rsp.target == mmsd_pkg::MMSD_TGT_UPPER);
	cov_special: cover property (@(posedge i_sys_clk) o_data_rsp.target == mmsd_pkg::MMSD_TGT_SPECIAL);
	cov_bank3: cover property (@(posedge i_sys_clk) o_data_rsp.index[7:3] == 5'h03);
	cov_extra: cover property (@(posedge i_sys_clk) o_code_rsp.extra_sector);
	cov_factory: cover property (@(posedge i_sys_clk) o_code_rsp.factory);
endmodule
`default_nettype wire

// ==== testbench/mmsd_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mmsd_core_model (
	input  wire logic                     i_sys_clk,
	output var  mmsd_pkg::mmsd_data_req_t o_data_req,
	output var  logic                     o_code_valid,
	output var  logic [15:0]              o_code_addr
);
	initial begin
		o_data_req = '0;
		o_code_valid = 1'b0;
		o_code_addr = 16'h0000;
	end
	// caller launches one access per cycle, just after the edge
	task automatic put(input mmsd_pkg::mmsd_mode_t m, input logic [15:0] a,
		input logic [1:0] b, input logic [15:0] c);
		o_data_req <= '{1'b1, m, a, b};
		o_code_valid <= 1'b1;
		o_code_addr <= c;
	endtask
	// drop both valids, leaving the last code address in place
	task automatic idle();
		o_data_req <= '0;
		o_code_valid <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== testbench/tb_mcu_memory_space_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_mcu_memory_space_decoder;
	logic                     i_sys_clk = 1'b0;
	logic                     i_rst = 1'b1;
	mmsd_pkg::mmsd_data_req_t data_req;
	logic                     code_valid;
	logic [15:0]              code_addr;
	mmsd_pkg::mmsd_data_rsp_t o_data_rsp;
	mmsd_pkg::mmsd_code_rsp_t o_code_rsp;
	mmsd_pkg::mmsd_data_rsp_t plain_data_rsp;
	int                       n_errors = 0;
	int                       num_checks = 0;
	int                       cycles = 0;
	always #5 i_sys_clk = ~i_sys_clk;
	mmsd_core_model core (.i_sys_clk(i_sys_clk), .o_data_req(data_req),
		.o_code_valid(code_valid), .o_code_addr(code_addr));
	mmsd_decoder dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_data_req(data_req),
		.i_code_valid(code_valid), .i_code_addr(code_addr),
		.o_data_rsp(o_data_rsp), .o_code_rsp(o_code_rsp));
	// variant without the extra data ram
	mmsd_decoder #(.HAS_EXTRA_RAM(1'b0)) dut_plain (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.i_data_req(data_req), .i_code_valid(code_valid), .i_code_addr(code_addr),
		.o_data_rsp(plain_data_rsp), .o_code_rsp());
	// ==========================================
	// helpers
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_errors++;
			end_of_test();
		end
	end
	// drive one access, then land just after the edge that answers it
	task automatic step(mmsd_pkg::mmsd_mode_t m, logic [15:0] a, logic [1:0] b,
		logic [15:0] c);
		core.put(m, a, b, c);
		@(posedge i_sys_clk);
		#1;
	endtask
	function automatic mmsd_pkg::mmsd_data_rsp_t dr(mmsd_pkg::mmsd_target_t t,
		logic [9:0] i, logic bt, logic bk);
		return '{1'b1, t, i, bt, bk};
	endfunction
	// ==========================================
	// scenarios
	task automatic t_reset();
		repeat (4) @(posedge i_sys_clk);
		#1;
		`CHK(o_data_rsp, '0)
		`CHK(o_code_rsp, '0)
		i_rst = 1'b0;
		$display("test reset done");
	endtask
	task automatic t_modes();
		step(mmsd_pkg::MMSD_INDIRECT, 16'h0090, 2'h0, 16'h0000);
		`CHK(o_data_rsp, dr(mmsd_pkg::MMSD_TGT_UPPER, 10'h090, 1'b0, 1'b0))
		step(mmsd_pkg::MMSD_DIRECT, 16'h0090, 2'h0, 16'h0000);
		`CHK(o_data_rsp, dr(mmsd_pkg::MMSD_TGT_SPECIAL, 10'h090, 1'b0, 1'b0))
		step(mmsd_pkg::MMSD_DIRECT, 16'h0045, 2'h0, 16'h0000);
		`CHK(o_data_rsp, dr(mmsd_pkg::MMSD_TGT_LOW, 10'h045, 1'b0, 1'b0))
		step(mmsd_pkg::MMSD_INDIRECT, 16'h0045, 2'h0, 16'h0000);
		`CHK(o_data_rsp, dr(mmsd_pkg::MMSD_TGT_LOW, 10'h045, 1'b0, 1'b0))
		$display("test modes done");
	endtask
	task automatic t_banks();
		step(mmsd_pkg::MMSD_REGREF, 16'h0005, 2'h3, 16'h0000);
		`CHK(o_data_rsp, dr(mmsd_pkg::MMSD_TGT_LOW, 10'h01d, 1'b0, 1'b1))
		step(mmsd_pkg::MMSD_REGREF, 16'h0007, 2'h1, 16'h0000);
		`CHK(o_data_rsp.index, 10'h00f)
		step(mmsd_pkg::MMSD_DIRECT, 16'h002f, 2'h0, 16'h0000);
		`CHK(o_data_rsp.bit_region, 1'b1)
		step(mmsd_pkg::MMSD_INDIRECT, 16'h0030, 2'h0, 16'h0000);
		`CHK(o_data_rsp.bit_region, 1'b0)
		$display("test banks done");
	endtask
	task automatic t_extra_ram();
		step(mmsd_pkg::MMSD_EXTDATA, 16'h03ff, 2'h0, 16'h0000);
		`CHK(o_data_rsp, dr(mmsd_pkg::MMSD_TGT_EXTRA, 10'h3ff, 1'b0, 1'b0))
		`CHK(plain_data_rsp.target, mmsd_pkg::MMSD_TGT_NONE)
		step(mmsd_pkg::MMSD_EXTDATA, 16'h0400, 2'h0, 16'h0000);
		`CHK(o_data_rsp.target, mmsd_pkg::MMSD_TGT_NONE)
		$display("test extra ram done");
	endtask
	task automatic t_flash();
		step(mmsd_pkg::MMSD_DIRECT, 16'h0000, 2'h0, 16'h0400);
		`CHK({o_code_rsp.user, o_code_rsp.sector}, {1'b1, 5'h02})
		`CHK(o_code_rsp.valid, 1'b1)
		step(mmsd_pkg::MMSD_DIRECT, 16'h0000, 2'h0, 16'h1dff);
		`CHK({o_code_rsp.user, o_code_rsp.factory, o_code_rsp.sector}, 7'h4e)
		step(mmsd_pkg::MMSD_DIRECT, 16'h0000, 2'h0, 16'h2000);
		`CHK({o_code_rsp.extra_sector, o_code_rsp.user, o_code_rsp.sector}, 7'h50)
		step(mmsd_pkg::MMSD_DIRECT, 16'h0000, 2'h0, 16'h1e00);
		`CHK({o_code_rsp.user, o_code_rsp.factory, o_code_rsp.sector}, 7'h2f)
		step(mmsd_pkg::MMSD_DIRECT, 16'h0000, 2'h0, 16'h1fff);
		`CHK(o_code_rsp.factory, 1'b1)
		step(mmsd_pkg::MMSD_DIRECT, 16'h0000, 2'h0, 16'h207f);
		`CHK({o_code_rsp.extra_sector, o_code_rsp.sector}, 6'h30)
		step(mmsd_pkg::MMSD_DIRECT, 16'h0000, 2'h0, 16'h2080);
		`CHK({o_code_rsp.extra_sector, o_code_rsp.invalid}, 2'h1)
		$display("test flash done");
	endtask
	task automatic t_midreset();
		i_rst = 1'b1;
		step(mmsd_pkg::MMSD_INDIRECT, 16'h0090, 2'h0, 16'h0400);
		`CHK(o_data_rsp, '0)
		`CHK(o_code_rsp, '0)
		i_rst = 1'b0;
		core.idle();
		@(posedge i_sys_clk);
		#1;
		`CHK({o_data_rsp.valid, o_code_rsp.valid}, 2'h0)
		step(mmsd_pkg::MMSD_INDIRECT, 16'h0090, 2'h0, 16'h0400);
		`CHK(o_data_rsp, dr(mmsd_pkg::MMSD_TGT_UPPER, 10'h090, 1'b0, 1'b0))
		$display("test mid reset done");
	endtask
	initial begin
		t_reset();
		t_modes();
		t_banks();
		t_extra_ram();
		t_flash();
		t_midreset();
		end_of_test();
	end
endmodule
`default_nettype wire
